// *** verilog/ioc_consts.vh ***
// Purpose: Shared constants for the I/O command port.
// Assumes: APB byte addresses, 32-bit data, one word per register.
// Notes:   Offsets, fields and resets are named here only.
`ifndef IOC_CONSTS_VH
`define IOC_CONSTS_VH
`define IOC_ADDR_W        8
`define IOC_OFS_CMD       8'h00
`define IOC_OFS_ARG       8'h04
`define IOC_OFS_RESULT    8'h08
`define IOC_OFS_STATUS    8'h0C
`define IOC_OFS_OUT       8'h10
`define IOC_OFS_IN        8'h14
`define IOC_OFS_POLARITY  8'h18
`define IOC_OFS_ADCCFG    8'h1C
`define IOC_OFS_ADCRAW    8'h20
`define IOC_OP_SET_BIT    4'h1
`define IOC_OP_CLR_BIT    4'h2
`define IOC_OP_VALUE      4'h3
`define IOC_OP_PORT1      4'h4
`define IOC_OP_PORT2      4'h5
`define IOC_OP_RD_OUT     4'h6
`define IOC_OP_RD_IN      4'h7
`define IOC_OP_BANK       4'h8
`define IOC_OP_IN_TRIP    4'h9
`define IOC_OP_ADC_RD     4'hA
`define IOC_OP_ADC_TRIP   4'hB
`define IOC_OP_DAC_SET    4'hC
`define IOC_OP_DAC_RD     4'hD
`define IOC_OP_NONE       4'h0
`define IOC_F_OP          3:0
`define IOC_F_BITNUM      3:0
`define IOC_F_OPND        31:8
`define IOC_F_BANK0       7:0
`define IOC_F_BANK1       15:8
`define IOC_F_MASK        15:0
`define IOC_F_LEVELS      31:16
`define IOC_F_ALEVEL      15:4
`define IOC_F_DIR         16
`define IOC_F_BANKSEL     0
`define IOC_F_CH          2:0
`define IOC_F_POL         15:0
`define IOC_F_DIFF        0
`define IOC_ADC_FULL      12'hFFF
`define IOC_ADC_SHIFT     3
`define IOC_ZERO32        32'h0000_0000
`define IOC_ZERO16        16'h0000
`define IOC_ZERO8         8'h00
`define IOC_ZERO12        12'h000
`endif

// *** verilog/ioc_sync.v ***
// Purpose: Three-stage synchroniser for a bus of field inputs.
// Assumes: Inputs are asynchronous to SYS_CLK.
// Notes:   A change is taken once stages two and three agree.
`timescale 1ns/10ps
module ioc_sync
#(
    parameter W     = 16,
    parameter WHOLE = 0
)
(
    // Clock and reset.
    input  wire         clk,
    input  wire         rst_n,
    // Data.
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer i;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // A multi-bit code must move as one word, or a torn value leaks out.
            if (WHOLE == 0)
            begin
                for (i = 0; i < W; i = i + 1)
                    if (s2_ff[i] == s3_ff[i])
                        q_out[i] <= s3_ff[i];
            end
            else if (s2_ff == s3_ff)
                q_out <= s3_ff;
        end
    end
endmodule // ioc_sync

// *** verilog/ioc_scale.v ***
// Purpose: Scale a 12-bit analog code to the record integer form.
// Assumes: Code already spans Vlo to Vhi as 0 to full scale.
// Notes:   Input record form is code times eight; output form is the code itself.
`timescale 1ns/10ps
`include "ioc_consts.vh"
module ioc_scale
(
    // Code in.
    input  wire [11:0] code,
    // Scaled record values.
    output wire [15:0] adc_rec,
    output wire [15:0] dac_rec
);
    assign adc_rec = {1'b0, code, 3'b000};
    assign dac_rec = {4'h0, code};
endmodule // ioc_scale

// *** verilog/ioc_top.v ***
// Purpose: APB command port for digital and analog I/O.
// Assumes: Host writes ARG then CMD; commands run one at a time.
// Notes:   Trip points keep BUSY high until their condition holds.
// Summary of operation
// [RQ1] Set-bit and clear-bit commands drive one named output high or low.
// [RQ2] Value command sets output if operand non-zero, clears it otherwise.
// [RQ3] Port write loads whole bank, bit i weighted two to the i.
// [RQ4] Two-operand port write: first to bank zero, second to bank one.
// [RQ5] Present state of any single output readable by output number.
// [RQ6] Level of a single input readable by input number.
// [RQ7] Per-input polarity register chooses which level counts as active.
// [RQ8] Whole input bank reported in one response, bank zero or one.
// [RQ9] Input trip waits until every listed input is at its level.
// [RQ10] Analog reads give a 12-bit value; width is a parameter.
// [RQ11] Record form of analog input is scaled code times eight.
// [RQ12] Channel config selects eight single-ended (default) or four differential.
// [RQ13] Analog trip waits for rise above (0) or fall below (1) level.
// [RQ14] If analog condition already holds, the trip completes at once.
// [RQ15] Analog output set per channel at 12 bits and readable back.
// [RQ16] Record form of analog output is the code with no multiply.
// [RQ17] Standard range 0 V to 5 V maps to code 0 to full scale.
// [RQ18] Two 8-bit output banks and two 8-bit input banks.
`timescale 1ns/10ps
`include "ioc_consts.vh"
module ioc_top
#(
    parameter AW = 12
)
(
    // Clock and reset.
    input  wire          SYS_CLK,
    input  wire          RSTN,
    // APB slave.
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output wire [31:0]   PRDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    // Digital field pins.
    input  wire [15:0]   DIN,
    output wire [15:0]   DOUT,
    // Analog converters, eight single-ended channels of codes.
    input  wire [95:0]   ADC_CODES,
    output wire [95:0]   DAC_CODES,
    output wire          ADC_DIFF_MODE
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [7:0]    out_bank0_ff;  // [RQ18]
    reg  [7:0]    out_bank1_ff;  // [RQ18]
    reg  [15:0]   pol_ff;
    reg           diff_ff;
    reg  [31:0]   arg_ff;
    reg  [3:0]    op_ff;
    reg           busy_ff;
    reg  [31:0]   result_ff;
    reg  [AW-1:0] dac_ff [0:7];
    reg  [31:0]   prdata_ff;
    wire [15:0]   din_s;
    wire [95:0]   adc_s;
    wire [15:0]   act_lvl;
    wire [15:0]   out_all;
    wire [AW-1:0] adc_sel;
    wire [15:0]   adc_rec;
    wire [15:0]   dac_rec;
    wire [2:0]    ch;
    wire          wr;
    wire          rd;
    wire          cmd_wr;
    wire          in_trip_ok;
    wire          adc_trip_ok;
    integer       k;
    // ARG and PWDATA fields, named once so the engine reads no bare positions.
    wire [3:0]    wr_op;
    wire [3:0]    f_bitnum;
    wire          f_operand_nz;
    wire [7:0]    f_bank0;
    wire [7:0]    f_bank1;
    wire [15:0]   f_mask;
    wire [15:0]   f_levels;
    wire [AW-1:0] f_alevel;
    wire          f_fall;
    wire          f_banksel;

    assign out_all = {out_bank1_ff, out_bank0_ff};
    assign DOUT = out_all;
    assign ADC_DIFF_MODE = diff_ff;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = prdata_ff;
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & ~PENABLE & ~PWRITE;
    assign cmd_wr = wr & (PADDR == `IOC_OFS_CMD) & ~busy_ff;
    assign ch = arg_ff[`IOC_F_CH];

    ////////////////////////////////////////////////////////////////////////////
    // Field decode. Bit numbers span both banks: the top bit picks bank one.
    assign wr_op        = PWDATA[`IOC_F_OP];
    assign f_bitnum     = arg_ff[`IOC_F_BITNUM];
    assign f_operand_nz = |arg_ff[`IOC_F_OPND]; // [RQ2]
    assign f_bank0      = arg_ff[`IOC_F_BANK0];
    assign f_bank1      = arg_ff[`IOC_F_BANK1];
    assign f_mask       = arg_ff[`IOC_F_MASK];
    assign f_levels     = arg_ff[`IOC_F_LEVELS];
    assign f_alevel     = arg_ff[`IOC_F_ALEVEL];
    assign f_fall       = arg_ff[`IOC_F_DIR];
    assign f_banksel    = arg_ff[`IOC_F_BANKSEL];

    // Replace one of the sixteen output bits and keep the other fifteen.
    function [15:0] put_bit;
        input [15:0] word;
        input [3:0]  n;
        input        v;
        begin
            put_bit    = word;
            put_bit[n] = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.
    ioc_sync #(.W(16)) u_din
    (
        .clk   (SYS_CLK),
        .rst_n (RSTN),
        .d_in  (DIN),
        .q_out (din_s)
    );
    // Converter codes are taken only when a whole word has held for two samples,
    // which adds a cycle of latency while a code is still settling.
    ioc_sync #(.W(96), .WHOLE(1)) u_adc
    (
        .clk   (SYS_CLK),
        .rst_n (RSTN),
        .d_in  (ADC_CODES),
        .q_out (adc_s)
    );

    // A set polarity bit marks low as the active level.
    assign act_lvl = din_s ^ pol_ff; // [RQ7]

    // In differential mode channel n pairs inputs 2n and 2n+1; the lower one
    // carries the converted difference, so only four channels are addressable.
    function [AW-1:0] adc_pick;
        input [95:0] codes;
        input [2:0]  c;
        input        dm;
        reg   [2:0]  e;
        begin
            e = dm ? {c[1:0], 1'b0} : c;
            adc_pick = codes[e*AW +: AW];
        end
    endfunction
    assign adc_sel = adc_pick(adc_s, ch, diff_ff); // [RQ12]

    ioc_scale u_scale
    (
        .code    (op_ff == `IOC_OP_DAC_RD ? dac_ff[ch] : adc_sel),
        .adc_rec (adc_rec), // [RQ11]
        .dac_rec (dac_rec)  // [RQ16]
    );

    // ARG for input trip: [15:0] mask of listed inputs, [31:16] wanted levels.
    assign in_trip_ok = ((act_lvl ^ f_levels) & f_mask) == `IOC_ZERO16; // [RQ9]
    // ARG for analog trip: [2:0] channel, [15:4] level, [16] direction. Both
    // compares are strict, so a channel sitting exactly on the level waits.
    assign adc_trip_ok = f_fall ? (adc_sel < f_alevel)
                                : (adc_sel > f_alevel); // [RQ13]

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_dac
            assign DAC_CODES[g*12 +: 12] = dac_ff[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Software-set registers. ARG is locked while a command runs, so a trip or
    // a conversion never sees its operand change underneath it.
    always @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            arg_ff  <= `IOC_ZERO32;
            pol_ff  <= `IOC_ZERO16;
            diff_ff <= 1'b0;
        end
        else
        begin
            if (wr && PADDR == `IOC_OFS_ARG && !busy_ff)
                arg_ff <= PWDATA;
            if (wr && PADDR == `IOC_OFS_POLARITY)
                pol_ff <= PWDATA[`IOC_F_POL]; // [RQ7]
            if (wr && PADDR == `IOC_OFS_ADCCFG)
                diff_ff <= PWDATA[`IOC_F_DIFF]; // [RQ12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command engine. Output and digital readback commands finish on the issuing edge.
    // Conversions, DAC readback and trips raise BUSY instead; a command written while BUSY
    // is dropped with no error response, so software must poll STATUS first.
    always @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            out_bank0_ff <= `IOC_ZERO8;
            out_bank1_ff <= `IOC_ZERO8;
            op_ff        <= `IOC_OP_NONE;
            busy_ff      <= 1'b0;
            result_ff    <= `IOC_ZERO32;
            for (k = 0; k < 8; k = k + 1)
                dac_ff[k] <= {AW{1'b0}};
        end
        else
        begin
            if (cmd_wr)
            begin
                op_ff <= wr_op;
                case (wr_op)
                    `IOC_OP_SET_BIT:
                        {out_bank1_ff, out_bank0_ff} <=
                            put_bit(out_all, f_bitnum, 1'b1); // [RQ1]
                    `IOC_OP_CLR_BIT:
                        {out_bank1_ff, out_bank0_ff} <=
                            put_bit(out_all, f_bitnum, 1'b0); // [RQ1]
                    // ARG [3:0] output number, [31:8] operand.
                    `IOC_OP_VALUE:
                        {out_bank1_ff, out_bank0_ff} <=
                            put_bit(out_all, f_bitnum, f_operand_nz); // [RQ2]
                    `IOC_OP_PORT1:
                        out_bank0_ff <= f_bank0; // [RQ3]
                    `IOC_OP_PORT2:
                    begin
                        out_bank0_ff <= f_bank0; // [RQ4]
                        out_bank1_ff <= f_bank1; // [RQ4]
                    end
                    `IOC_OP_RD_OUT:
                        result_ff <= {31'h0, out_all[f_bitnum]}; // [RQ5]
                    `IOC_OP_RD_IN:
                        result_ff <= {31'h0, act_lvl[f_bitnum]}; // [RQ6]
                    `IOC_OP_BANK:
                        result_ff <= {24'h0, f_banksel ? act_lvl[`IOC_F_BANK1]
                                                       : act_lvl[`IOC_F_BANK0]}; // [RQ8]
                    `IOC_OP_IN_TRIP, `IOC_OP_ADC_TRIP, `IOC_OP_ADC_RD, `IOC_OP_DAC_RD:
                        busy_ff <= 1'b1;
                    `IOC_OP_DAC_SET:
                        dac_ff[ch] <= f_alevel; // [RQ15]
                    default:
                        result_ff <= result_ff;
                endcase
            end
            else if (busy_ff)
            begin
                // One cycle after issue the selected code is settled; trips hold here.
                case (op_ff)
                    `IOC_OP_IN_TRIP:
                        if (in_trip_ok) busy_ff <= 1'b0; // [RQ9]
                    `IOC_OP_ADC_TRIP:
                        if (adc_trip_ok) busy_ff <= 1'b0; // [RQ14]
                    `IOC_OP_ADC_RD:
                    begin
                        result_ff <= {4'h0, adc_sel, adc_rec}; // [RQ10] [RQ17]
                        busy_ff   <= 1'b0;
                    end
                    `IOC_OP_DAC_RD:
                    begin
                        result_ff <= {4'h0, dac_ff[ch], dac_rec}; // [RQ15]
                        busy_ff   <= 1'b0;
                    end
                    default:
                        busy_ff <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data is captured in the setup cycle and valid in the access cycle.
    // Unmapped offsets read as zero so that software can probe the map safely.
    always @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
            prdata_ff <= `IOC_ZERO32;
        else if (rd)
        begin
            case (PADDR)
                `IOC_OFS_ARG:      prdata_ff <= arg_ff;
                `IOC_OFS_CMD:      prdata_ff <= {28'h0, op_ff};
                `IOC_OFS_RESULT:   prdata_ff <= result_ff;
                `IOC_OFS_STATUS:   prdata_ff <= {31'h0, busy_ff};
                `IOC_OFS_OUT:      prdata_ff <= {16'h0, out_all};
                `IOC_OFS_IN:       prdata_ff <= {16'h0, act_lvl};
                `IOC_OFS_POLARITY: prdata_ff <= {16'h0, pol_ff};
                `IOC_OFS_ADCCFG:   prdata_ff <= {31'h0, diff_ff};
                `IOC_OFS_ADCRAW:   prdata_ff <= {20'h0, adc_sel};
                default:           prdata_ff <= `IOC_ZERO32;
            endcase
        end
    end
endmodule // ioc_top

// *** verif/ioc_field_model.sv ***
// Purpose: Field side of the I/O command port.
// Assumes: The bench sets each level.
// Notes:   No delay; the design's synchroniser absorbs it.
`timescale 1ns/10ps
////////////////////////////////
module ioc_field_model
(
    // Wanted levels.
    input  wire logic [15:0] din_set,
    input  wire logic [95:0] adc_set,
    // Field pins.
    output wire logic [15:0] din,
    output wire logic [95:0] adc
);
    assign din = din_set;
    assign adc = adc_set;
endmodule // ioc_field_model

// *** verif/ioc_props_properties.sv ***
// Purpose: Port checks for the I/O command port.
// Assumes: Commands are written only while idle.
// Notes:   Bound into ioc_top below.
`timescale 1ns/10ps
////////////////////////////////
module ioc_props
(
    // Clock, reset, bus.
    input wire logic        SYS_CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    // Outputs.
    input wire logic [15:0] DOUT,
    input wire logic [95:0] DAC_CODES,
    input wire logic        ADC_DIFF_MODE
);
    wire        wr  = PSEL && PENABLE && PWRITE;
    wire        cmd = wr && PADDR == 8'h00;
    reg  [31:0] arg_ff;
    // A copy of ARG ties each command's effect to its operand.
    always @(posedge SYS_CLK or negedge RSTN)
        if (!RSTN)
            arg_ff <= 32'h0;
        else if (wr && PADDR == 8'h04)
            arg_ff <= PWDATA;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    set_bit_a: assert property (cmd && PWDATA[3:0] == 4'h1 |=> DOUT[arg_ff[3:0]])
        else $error("set bit");
    clr_bit_a: assert property (cmd && PWDATA[3:0] == 4'h2 |=> !DOUT[arg_ff[3:0]])
        else $error("clear bit");
    value_bit_a: assert property (cmd && PWDATA[3:0] == 4'h3 |=>
        DOUT[arg_ff[3:0]] == (arg_ff[31:8] != 24'h0)) else $error("value bit");
    port_one_a: assert property (cmd && PWDATA[3:0] == 4'h4 |=>
        DOUT[7:0] == arg_ff[7:0] && $stable(DOUT[15:8])) else $error("port one");
    port_two_a: assert property (cmd && PWDATA[3:0] == 4'h5 |=> DOUT == arg_ff[15:0])
        else $error("port two");
    dac_set_a: assert property (cmd && PWDATA[3:0] == 4'hC |=>
        DAC_CODES[arg_ff[2:0]*12 +: 12] == arg_ff[15:4]) else $error("dac set");
    diff_mode_a: assert property (wr && PADDR == 8'h1C |=>
        ADC_DIFF_MODE == $past(PWDATA[0])) else $error("diff mode");
    dout_hold_a: assert property (!cmd |=> $stable(DOUT))
        else $error("output moved");
endmodule // ioc_props
bind ioc_top ioc_props u_props (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .DOUT(DOUT),
    .DAC_CODES(DAC_CODES), .ADC_DIFF_MODE(ADC_DIFF_MODE));

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the I/O command port.
// Assumes: Zero-wait APB slave.
// Notes:   Seed 47; field inputs settle in five cycles.
`timescale 1ns/10ps
`include "ioc_consts.vh"
////////////////////////////////
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [15:0] din_set = 16'h0;
    logic [95:0] adc_set = 96'h0;
    logic [31:0] r, a;
    logic [15:0] eo, pol;
    logic [11:0] c;
    logic [3:0]  op;
    wire  [31:0] prd;
    wire         prdy, perr, dmode;
    wire  [15:0] din, dout;
    wire  [95:0] adc, dac;
    int          err_count = 0;
    int          checks_done = 0;
    int          i;
    always #10 clk = ~clk;
    ioc_field_model u_fld (.din_set(din_set), .adc_set(adc_set), .din(din), .adc(adc));
    ioc_top u_dut (.SYS_CLK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DIN(din),
        .DOUT(dout), .ADC_CODES(adc), .DAC_CODES(dac), .ADC_DIFF_MODE(dmode));
    function logic [31:0] rec(input logic [11:0] k, input logic d);
        rec = d ? {4'h0, k, 4'h0, k} : {4'h0, k, 1'b0, k, 3'h0};
    endfunction
    task print_verdict;
    begin
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
    begin
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
        end
    end
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= ad;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (prdy !== 1'b1 && n < 50);
        r = prd;
        if (prdy !== 1'b1)
        begin
            err_count++;
            print_verdict;
        end
        psel <= 1'b0;
        pen  <= 1'b0;
    end
    endtask
    task idle;
        int n;
    begin
        n = 0;
        do
        begin
            apb(1'b0, `IOC_OFS_STATUS, 32'h0);
            n++;
        end
        while (r[0] !== 1'b0 && n < 200);
        chk(r[0], 1'b0);
        if (r[0] !== 1'b0)
            print_verdict;
    end
    endtask
    task run(input logic [3:0] o, input logic [31:0] d, input logic rd);
    begin
        apb(1'b1, `IOC_OFS_ARG, d);
        apb(1'b1, `IOC_OFS_CMD, {28'h0, o});
        if (rd)
        begin
            idle;
            apb(1'b0, `IOC_OFS_RESULT, 32'h0);
        end
    end
    endtask
    task trip(input logic [3:0] o, input logic [31:0] d, input logic b);
    begin
        run(o, d, 1'b0);
        repeat (3) @(posedge clk);
        apb(1'b0, `IOC_OFS_STATUS, 32'h0);
        chk(r[0], b);
    end
    endtask
    initial
    begin
        void'($urandom(47));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk({perr, dmode, dac != 96'h0, dout}, 32'h0);
        apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        apb(1'b0, 8'h3C, 32'h0);
        chk(r, 32'h0);
        run(4'h5, 32'h0700, 1'b1);
        eo = 16'h0700;
        chk(dout, eo);
        for (i = 0; i < 24; i++)
        begin
            a = $urandom;
            c = 12'($urandom);
            if (c[3])
                a[31:8] = 24'h0;
            op = c[2] ? 4'h5 : 4'h1 + {2'h0, c[1:0]};
            case (op)
                4'h1: eo[a[3:0]] = 1'b1;
                4'h2: eo[a[3:0]] = 1'b0;
                4'h3: eo[a[3:0]] = |a[31:8];
                4'h4: eo[7:0] = a[7:0];
                default: eo = a[15:0];
            endcase
            run(op, a, 1'b1);
            chk(dout, eo);
            apb(1'b0, `IOC_OFS_OUT, 32'h0);
            chk(r, eo);
            run(4'h6, a, 1'b1);
            chk(r, eo[a[3:0]]);
        end
        for (i = 0; i < 4; i++)
        begin
            din_set <= 16'($urandom);
            pol = 16'($urandom);
            apb(1'b1, `IOC_OFS_POLARITY, pol);
            repeat (5) @(posedge clk);
            apb(1'b0, `IOC_OFS_IN, 32'h0);
            chk(r, din_set ^ pol);
            apb(1'b1, `IOC_OFS_POLARITY, 32'h0);
            run(4'h8, i % 2, 1'b1);
            chk(r, din_set[8*(i%2) +: 8]);
            run(4'h7, i * 5, 1'b1);
            chk(r, din_set[i*5]);
        end
        din_set <= 16'h00C0;
        trip(4'h9, 32'h0080_00C0, 1'b1);
        din_set <= 16'h0080;
        idle;
        adc_set <= {$urandom, $urandom, 20'($urandom), 12'hFFF};
        repeat (5) @(posedge clk);
        for (i = 0; i < 8; i++)
        begin
            run(4'hA, i, 1'b1);
            chk(r, rec(adc_set[i*12 +: 12], 1'b0));
        end
        apb(1'b1, `IOC_OFS_ADCCFG, 32'h1);
        run(4'hA, 32'h5, 1'b1);
        chk(r, rec(adc_set[24 +: 12], 1'b0));
        apb(1'b0, `IOC_OFS_ADCRAW, 32'h0);
        chk(r, adc_set[24 +: 12]);
        apb(1'b0, `IOC_OFS_ADCCFG, 32'h0);
        chk(r, 32'h1);
        chk(dmode, 1'b1);
        apb(1'b1, `IOC_OFS_ADCCFG, 32'h0);
        adc_set[23:12] <= 12'h800;
        repeat (5) @(posedge clk);
        trip(4'hB, 32'h0_7FF1, 1'b0);
        trip(4'hB, 32'h0_8001, 1'b1);
        adc_set[23:12] <= 12'h801;
        idle;
        trip(4'hB, 32'h1_8021, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            c = i ? 12'($urandom) : 12'hFFF;
            run(4'hC, {16'h0, c, 4'(i)}, 1'b1);
            chk(dac[i*12 +: 12], c);
            run(4'hD, i, 1'b1);
            chk(r, rec(c, 1'b1));
        end
        print_verdict;
    end
endmodule // tb_top
